/* File: rtl/dtc_pkg.sv */
package dtc_pkg;

	// register addresses (special-function register space)
	localparam logic [7:0] DTC_ADDR_CTRL    = 8'h88;
	localparam logic [7:0] DTC_ADDR_MODE    = 8'h89;
	localparam logic [7:0] DTC_ADDR_A_LOW   = 8'h8a;
	localparam logic [7:0] DTC_ADDR_B_LOW   = 8'h8b;
	localparam logic [7:0] DTC_ADDR_A_HIGH  = 8'h8c;
	localparam logic [7:0] DTC_ADDR_B_HIGH  = 8'h8d;
	localparam logic [7:0] DTC_ADDR_CKDIV   = 8'h8e;
	localparam logic [7:0] DTC_ADDR_IRQ_ST  = 8'h90;
	localparam logic [7:0] DTC_ADDR_IRQ_CLR = 8'h91;
	localparam logic [7:0] DTC_ADDR_IRQ_EN  = 8'h92;

	// control register fields
	localparam int DTC_CTRL_B_FLAG = 7;
	localparam int DTC_CTRL_B_RUN  = 6;
	localparam int DTC_CTRL_A_FLAG = 5;
	localparam int DTC_CTRL_A_RUN  = 4;

	// mode register fields (per timer nibble)
	localparam int DTC_MODE_B_BASE = 4;
	localparam int DTC_MODE_A_BASE = 0;
	localparam int DTC_MODE_CT     = 2;

	// clock divider register fields
	localparam int DTC_CKDIV_B_SEL = 4;
	localparam int DTC_CKDIV_A_SEL = 3;

	// interrupt status bits
	localparam int DTC_IRQ_A = 0;
	localparam int DTC_IRQ_B = 1;

	// timer modes
	localparam logic [1:0] DTC_MODE_13BIT  = 2'h0;
	localparam logic [1:0] DTC_MODE_16BIT  = 2'h1;
	localparam logic [1:0] DTC_MODE_RELOAD = 2'h2;
	localparam logic [1:0] DTC_MODE_SPLIT  = 2'h3;

	// divide factors
	localparam logic [3:0] DTC_DIV_FAST = 4'h4;
	localparam logic [3:0] DTC_DIV_SLOW = 4'hc;

	localparam logic [4:0] DTC_PRESCALE_MAX = 5'h1f;
	localparam logic [7:0] DTC_BYTE_MAX     = 8'hff;
	localparam logic [7:0] DTC_ZERO8        = 8'h00;
	localparam logic [1:0] DTC_ZERO2        = 2'h0;
	localparam logic [3:0] DTC_DIV_ONE      = 4'h1;

	typedef enum logic [1:0] {
		DTC_RD_IDLE = 2'b01,
		DTC_RD_BUSY = 2'b10
	} dtc_rd_e;

	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] mode;
		logic [7:0] ckdiv;
		logic [7:0] a_low;
		logic [7:0] a_high;
		logic [7:0] b_low;
		logic [7:0] b_high;
		logic [3:0] a_pre;
		logic [3:0] b_pre;
		logic       a_pin;
		logic       b_pin;
		logic [1:0] irq_st;
		logic [1:0] irq_en;
		logic       irq;
		logic [7:0] rdata;
		dtc_rd_e    rd;
	} dtc_state_s;

endpackage

/* File: rtl/dtc_timer.sv */
// Function
// - timer a divides clock by 4 or 12
// - timer b divides clock by 4 or 12
// - timer mode counts divided clock while enabled
// - counter mode counts count pin falling edges
// - count pins sampled every system clock
// - count held as high and low bytes
// - timer b counts only while run set
// - timer a counts only while run set, except its mode 3 high half, which runs on timer b's run bit
// - timer b overflow sets its flag unless timer a is in mode 3
// - timer a overflow sets its flag
// - timer b flag cleared on service
// - timer a flag cleared on service
// - mode 0: 5-bit prescaler, 13-bit count
// - mode 1: full 16-bit cascade
// - mode 2: low byte reloads from high
// - mode 3: timer a split in two
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
module dtc_timer
	import dtc_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	input  wire logic       timer_a_count_pin_i,
	input  wire logic       timer_b_count_pin_i,
	input  wire logic       timer_a_ack_i,
	input  wire logic       timer_b_ack_i,
	output logic [7:0]      rdata_o,
	output logic            timer_a_overflow_flag_o,
	output logic            timer_b_overflow_flag_o,
	output logic            irq_o
);

	////////////////////////////////////////////////////////////////////////
	// helpers

	typedef struct packed {
		logic [7:0] low;
		logic [7:0] high;
		logic       ovf;
	} dtc_cnt_t;

	// one tick of a timer in the given mode
	function automatic dtc_cnt_t dtc_step(input logic [1:0] md, input logic [7:0] lo,
			input logic [7:0] hi);
		dtc_cnt_t r;
		r.low  = lo;
		r.high = hi;
		r.ovf  = 1'b0;
		case (md)
			DTC_MODE_13BIT: begin
				if (lo[4:0] == DTC_PRESCALE_MAX) begin
					r.low  = {lo[7:5], 5'h00};
					r.high = hi + 8'h01;
					r.ovf  = (hi == DTC_BYTE_MAX);
				end else begin
					r.low = lo + 8'h01;
				end
			end
			DTC_MODE_16BIT: begin
				r.low = lo + 8'h01;
				if (lo == DTC_BYTE_MAX) begin
					r.high = hi + 8'h01;
					r.ovf  = (hi == DTC_BYTE_MAX);
				end
			end
			DTC_MODE_RELOAD: begin
				if (lo == DTC_BYTE_MAX) begin
					r.low = hi;
					r.ovf = 1'b1;
				end else begin
					r.low = lo + 8'h01;
				end
			end
			default: begin
				// split: low half only, high half handled separately
				r.low = lo + 8'h01;
				r.ovf = (lo == DTC_BYTE_MAX);
			end
		endcase
		return r;
	endfunction

	// divider prescale: terminal count reached or passed; a switch from 12 to 4
	// while the divider stands above 3 would otherwise wait for a 4-bit wrap
	function automatic logic dtc_div_tick(input logic sel, input logic [3:0] cnt);
		return (cnt >= ((sel ? DTC_DIV_FAST : DTC_DIV_SLOW) - DTC_DIV_ONE));
	endfunction

	////////////////////////////////////////////////////////////////////////
	// state

	dtc_state_s s_q;
	dtc_state_s s_d;

	always_comb begin
		logic       a_run;
		logic       b_run;
		logic       a_ct;
		logic       b_ct;
		logic [1:0] a_md;
		logic [1:0] b_md;
		logic       a_tick;
		logic       b_tick;
		logic       a_div;
		logic       b_div;
		logic       a_fall;
		logic       b_fall;
		logic       a_inc;
		logic       b_inc;
		logic       ah_inc;
		logic       a_ovf;
		logic       b_ovf;
		dtc_cnt_t   a_nx;
		dtc_cnt_t   b_nx;

		s_d = s_q;

		a_run = s_q.ctrl[DTC_CTRL_A_RUN];
		b_run = s_q.ctrl[DTC_CTRL_B_RUN];
		a_ct  = s_q.mode[DTC_MODE_A_BASE + DTC_MODE_CT];
		b_ct  = s_q.mode[DTC_MODE_B_BASE + DTC_MODE_CT];
		a_md  = s_q.mode[DTC_MODE_A_BASE +: 2];
		b_md  = s_q.mode[DTC_MODE_B_BASE +: 2];

		// pins taken as synchronous; one register is the previous sample
		s_d.a_pin = timer_a_count_pin_i;
		s_d.b_pin = timer_b_count_pin_i;
		a_fall = s_q.a_pin & ~timer_a_count_pin_i;
		b_fall = s_q.b_pin & ~timer_b_count_pin_i;

		// free-running dividers, restarted when they reach terminal count
		a_div = dtc_div_tick(s_q.ckdiv[DTC_CKDIV_A_SEL], s_q.a_pre);
		b_div = dtc_div_tick(s_q.ckdiv[DTC_CKDIV_B_SEL], s_q.b_pre);
		s_d.a_pre = a_div ? 4'h0 : s_q.a_pre + 4'h1;
		s_d.b_pre = b_div ? 4'h0 : s_q.b_pre + 4'h1;

		a_tick = a_ct ? a_fall : a_div;
		b_tick = b_ct ? b_fall : b_div;

		a_inc  = a_tick & a_run;
		// in split mode the high half of a steals timer b's run bit and
		// always counts the divided clock
		ah_inc = (a_md == DTC_MODE_SPLIT) & a_div & b_run;
		// timer b keeps counting in split mode, but loses its flag
		b_inc  = b_tick & b_run;

		a_nx = dtc_step(a_md, s_q.a_low, s_q.a_high);
		b_nx = dtc_step((b_md == DTC_MODE_SPLIT) ? DTC_MODE_16BIT : b_md,
			s_q.b_low, s_q.b_high);

		a_ovf = a_inc & a_nx.ovf;
		b_ovf = 1'b0;
		if (a_inc) begin
			s_d.a_low = a_nx.low;
			if (a_md != DTC_MODE_SPLIT) begin
				s_d.a_high = a_nx.high;
			end
		end
		if (ah_inc) begin
			s_d.a_high = s_q.a_high + 8'h01;
			b_ovf      = (s_q.a_high == DTC_BYTE_MAX);
		end
		if (b_inc) begin
			s_d.b_low  = b_nx.low;
			s_d.b_high = b_nx.high;
			if (a_md != DTC_MODE_SPLIT) begin
				b_ovf = b_nx.ovf;
			end
		end

		////////////////////////////////////////////////////////////////////
		// register writes

		if (wr_i) begin
			case (addr_i)
				DTC_ADDR_CTRL:    s_d.ctrl  = wdata_i;
				DTC_ADDR_MODE:    s_d.mode  = wdata_i;
				DTC_ADDR_CKDIV:   s_d.ckdiv = wdata_i;
				DTC_ADDR_A_LOW:   s_d.a_low  = wdata_i;
				DTC_ADDR_A_HIGH:  s_d.a_high = wdata_i;
				DTC_ADDR_B_LOW:   s_d.b_low  = wdata_i;
				DTC_ADDR_B_HIGH:  s_d.b_high = wdata_i;
				DTC_ADDR_IRQ_EN:  s_d.irq_en = wdata_i[1:0];
				DTC_ADDR_IRQ_CLR: s_d.irq_st = s_q.irq_st & ~wdata_i[1:0];
				default: begin
				end
			endcase
		end

		// service acknowledge clears flags; a new overflow wins over both
		if (timer_a_ack_i) begin
			s_d.ctrl[DTC_CTRL_A_FLAG] = 1'b0;
		end
		if (timer_b_ack_i) begin
			s_d.ctrl[DTC_CTRL_B_FLAG] = 1'b0;
		end
		if (a_ovf) begin
			s_d.ctrl[DTC_CTRL_A_FLAG] = 1'b1;
			s_d.irq_st[DTC_IRQ_A]     = 1'b1;
		end
		if (b_ovf) begin
			s_d.ctrl[DTC_CTRL_B_FLAG] = 1'b1;
			s_d.irq_st[DTC_IRQ_B]     = 1'b1;
		end

		s_d.irq = |(s_d.irq_st & s_d.irq_en);

		////////////////////////////////////////////////////////////////////
		// register reads, data stand in the following cycle only

		s_d.rdata = DTC_ZERO8;
		s_d.rd    = rd_i ? DTC_RD_BUSY : DTC_RD_IDLE;
		if (rd_i) begin
			case (addr_i)
				DTC_ADDR_CTRL:   s_d.rdata = s_q.ctrl;
				DTC_ADDR_MODE:   s_d.rdata = s_q.mode;
				DTC_ADDR_CKDIV:  s_d.rdata = s_q.ckdiv;
				DTC_ADDR_A_LOW:  s_d.rdata = s_q.a_low;
				DTC_ADDR_A_HIGH: s_d.rdata = s_q.a_high;
				DTC_ADDR_B_LOW:  s_d.rdata = s_q.b_low;
				DTC_ADDR_B_HIGH: s_d.rdata = s_q.b_high;
				DTC_ADDR_IRQ_ST: s_d.rdata = {6'h00, s_q.irq_st};
				DTC_ADDR_IRQ_EN: s_d.rdata = {6'h00, s_q.irq_en};
				default:         s_d.rdata = DTC_ZERO8;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s_q        <= '0;
			s_q.a_pin  <= 1'b1;
			s_q.b_pin  <= 1'b1;
			s_q.rd     <= DTC_RD_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata_o                 = s_q.rdata;
	assign timer_a_overflow_flag_o = s_q.ctrl[DTC_CTRL_A_FLAG];
	assign timer_b_overflow_flag_o = s_q.ctrl[DTC_CTRL_B_FLAG];
	assign irq_o                   = s_q.irq;

endmodule

/* File: tb/dtc_pin_model.sv */
`timescale 1ns/100ps
module dtc_pin_model (
	input  wire logic clk_i,
	output logic      pin_a_o,
	output logic      pin_b_o
);
	initial {pin_b_o, pin_a_o} = 2'b11;
	// one-cycle phases: the narrowest pulse a per-clock sampler can see
	task automatic pulse(input logic sel, input int n);
		repeat (n) begin
			@(posedge clk_i);
			{pin_b_o, pin_a_o} <= sel ? 2'b01 : 2'b10;
			@(posedge clk_i);
			{pin_b_o, pin_a_o} <= 2'b11;
		end
	endtask
endmodule

/* File: tb/dtc_timer_assertions.sv */
`timescale 1ns/100ps
module dtc_timer_assertions
	import dtc_pkg::*;
(
	input wire logic       clk_i,
	input wire logic       rst_n_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic       timer_a_ack_i,
	input wire logic       timer_b_ack_i,
	input wire logic [7:0] rdata_o,
	input wire logic       timer_a_overflow_flag_o,
	input wire logic       timer_b_overflow_flag_o,
	input wire logic       irq_o
);
	wire logic fa = timer_a_overflow_flag_o;
	wire logic fb = timer_b_overflow_flag_o;
	wire logic cw = wr_i && addr_i == DTC_ADDR_CTRL;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	////////////////////////////////////////
	property p_rd_idle; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
	property p_rst; $rose(rst_n_i) |-> !fa && !fb && !irq_o; endproperty
	a_rst: assert property (p_rst) else $error("flags set after reset");
	property p_fall_a; $fell(fa) |-> $past(timer_a_ack_i) || $past(cw && !wdata_i[5]); endproperty
	a_fall_a: assert property (p_fall_a) else $error("flag a dropped alone");
	property p_fall_b; $fell(fb) |-> $past(timer_b_ack_i) || $past(cw && !wdata_i[7]); endproperty
	a_fall_b: assert property (p_fall_b) else $error("flag b dropped alone");
	// an overflow landing on the ack edge would win; stimulus stops timers first
	property p_ack_a; timer_a_ack_i && !cw |=> !fa; endproperty
	a_ack_a: assert property (p_ack_a) else $error("ack a kept flag");
	property p_ack_b; timer_b_ack_i && !cw |=> !fb; endproperty
	a_ack_b: assert property (p_ack_b) else $error("ack b kept flag");
	property p_ctl_rd;
		rd_i && addr_i == DTC_ADDR_CTRL |=> rdata_o[7] == $past(fb) && rdata_o[5] == $past(fa);
	endproperty
	a_ctl_rd: assert property (p_ctl_rd) else $error("flag read mismatch");
	property p_irq_off;
		wr_i && addr_i == DTC_ADDR_IRQ_EN && wdata_i[1:0] == 2'h0 |-> ##2 !irq_o;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("masked irq high");
endmodule

bind dtc_timer dtc_timer_assertions u_chk (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i,
	.rd_i, .timer_a_ack_i, .timer_b_ack_i, .rdata_o, .timer_a_overflow_flag_o,
	.timer_b_overflow_flag_o, .irq_o);

/* File: tb/dtc_timer_tb.sv */
`timescale 1ns/100ps
module dtc_timer_tb
	import dtc_pkg::*;
;
	logic       clk_i   = 1'b0;
	logic       rst_n_i = 1'b0;
	logic [7:0] addr_i  = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic       wr_i    = 1'b0;
	logic       rd_i    = 1'b0;
	logic       ack_a   = 1'b0;
	logic       ack_b   = 1'b0;
	wire logic  pin_a, pin_b, fa, fb, irq;
	wire logic [7:0] rdata;
	int         fails   = 0;
	int         checks  = 0;
	always #50 clk_i = ~clk_i;
	dtc_timer u_dut (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
		.timer_a_count_pin_i(pin_a), .timer_b_count_pin_i(pin_b), .timer_a_ack_i(ack_a),
		.timer_b_ack_i(ack_b), .rdata_o(rdata), .timer_a_overflow_flag_o(fa),
		.timer_b_overflow_flag_o(fb), .irq_o(irq));
	dtc_pin_model u_pins (.clk_i, .pin_a_o(pin_a), .pin_b_o(pin_b));
	////////////////////////////////////////
	task automatic chk(input string what, input logic [7:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, exp);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk("read data", rdata, exp);
	endtask
	task automatic ack(input logic b);
		@(posedge clk_i);
		ack_a <= !b;
		ack_b <= b;
		@(posedge clk_i);
		ack_a <= 1'b0;
		ack_b <= 1'b0;
		#1;
	endtask
	// stop keeps the flag bits as they stand, so a stop write clears nothing
	task automatic run(input logic [7:0] c, input int n);
		wr(DTC_ADDR_CTRL, c);
		repeat (n) @(posedge clk_i);
		wr(DTC_ADDR_CTRL, {fb, 1'b0, fa, 5'h00});
	endtask
	task automatic end_of_test;
		if (fails == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	////////////////////////////////////////
	task automatic t_div(input logic [7:0] ck, ea, eb);
		wr(DTC_ADDR_CKDIV, ck);
		wr(DTC_ADDR_A_LOW, 8'h00);
		wr(DTC_ADDR_B_LOW, 8'h00);
		run(8'h50, 118);
		repeat (30) @(posedge clk_i);
		rd(DTC_ADDR_A_LOW, ea);
		rd(DTC_ADDR_B_LOW, eb);
	endtask
	task automatic t_cnt;
		wr(DTC_ADDR_MODE, 8'h55);
		wr(DTC_ADDR_A_LOW, 8'h00);
		wr(DTC_ADDR_B_LOW, 8'h00);
		wr(DTC_ADDR_CTRL, 8'h50);
		u_pins.pulse(1'b0, 5);
		u_pins.pulse(1'b1, 3);
		wr(DTC_ADDR_CTRL, 8'h00);
		rd(DTC_ADDR_A_LOW, 8'h05);
		rd(DTC_ADDR_B_LOW, 8'h03);
	endtask
	task automatic t_ovf;
		wr(DTC_ADDR_MODE, 8'h22);
		wr(DTC_ADDR_CKDIV, 8'h18);
		wr(DTC_ADDR_IRQ_EN, 8'h03);
		wr(DTC_ADDR_A_HIGH, 8'hf0);
		wr(DTC_ADDR_A_LOW, 8'hfe);
		wr(DTC_ADDR_B_HIGH, 8'hf0);
		wr(DTC_ADDR_B_LOW, 8'hfe);
		run(8'h50, 18);
		rd(DTC_ADDR_A_LOW, 8'hf3);
		rd(DTC_ADDR_CTRL, 8'ha0);
		rd(DTC_ADDR_IRQ_ST, 8'h03);
		chk("irq", {7'h00, irq}, 8'h01);
		ack(1'b0);
		chk("flags", {6'h00, fb, fa}, 8'h02);
		ack(1'b1);
		chk("flags", {6'h00, fb, fa}, 8'h00);
		wr(DTC_ADDR_IRQ_EN, 8'h00);
		repeat (2) @(posedge clk_i);
		#1 chk("irq", {7'h00, irq}, 8'h00);
		wr(DTC_ADDR_IRQ_EN, 8'h03);
		repeat (2) @(posedge clk_i);
		#1 chk("irq", {7'h00, irq}, 8'h01);
		wr(DTC_ADDR_IRQ_CLR, 8'h03);
		repeat (2) @(posedge clk_i);
		#1 chk("irq", {7'h00, irq}, 8'h00);
	endtask
	task automatic t_split;
		wr(DTC_ADDR_MODE, 8'h10);
		wr(DTC_ADDR_A_HIGH, 8'h00);
		wr(DTC_ADDR_A_LOW, 8'hfe);
		run(8'h10, 18);
		rd(DTC_ADDR_A_LOW, 8'he3);
		rd(DTC_ADDR_A_HIGH, 8'h01);
		wr(DTC_ADDR_MODE, 8'h13);
		wr(DTC_ADDR_A_LOW, 8'h00);
		wr(DTC_ADDR_A_HIGH, 8'h00);
		run(8'h40, 18);
		rd(DTC_ADDR_A_LOW, 8'h00);
		rd(DTC_ADDR_A_HIGH, 8'h05);
	endtask
	////////////////////////////////////////
	initial begin
		#(100 * 5000);
		fails++;
		end_of_test;
	end
	initial begin
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(DTC_ADDR_CTRL, 8'h00);
		rd(DTC_ADDR_CKDIV, 8'h00);
		rd(8'h80, 8'h00);
		wr(DTC_ADDR_MODE, 8'h11);
		t_div(8'h10, 8'd10, 8'd30);
		t_div(8'h08, 8'd30, 8'd10);
		t_cnt;
		t_ovf;
		t_split;
		end_of_test;
	end
endmodule
